// ===== src/fabric_defines.vh
`ifndef FABRIC_DEFINES_VH
`define FABRIC_DEFINES_VH

// ==========================================================
// address map
// ==========================================================
// smallest decodable region is 1KB, so decode starts above bit 9
`define REGION_LSB 10
`define ADDR_WIDTH 32
`define DATA_WIDTH 32
`define SLAVE_COUNT 3
// region bases and masks are in units of 1KB (address bits 31:10)
`define SLAVE0_BASE 22'h000000
`define SLAVE0_MASK 22'h3FFFC0
`define SLAVE1_BASE 22'h080000
`define SLAVE1_MASK 22'h3FFFC0
`define SLAVE2_BASE 22'h100000
`define SLAVE2_MASK 22'h3FFFC0

// ==========================================================
// transfer types and responses
// ==========================================================
`define TRANS_IDLE 2'h0
`define TRANS_BUSY 2'h1
`define TRANS_NONSEQ 2'h2
`define TRANS_SEQ 2'h3
`define RESP_OKAY 1'h0
`define RESP_ERROR 1'h1

// ==========================================================
// timing counts
// ==========================================================
`define MAX_WAITS 16
`define DEFAULT_ERR_WAITS 0

`endif

// ===== src/default_responder.v
`timescale 1ns/1ps
`include "fabric_defines.vh"

// ==========================================================
// answers every access to unmapped space
// ==========================================================
module default_responder #(
	parameter ERR_WAITS = `DEFAULT_ERR_WAITS
) (
	input wire clock_i,
	input wire rst_b_i,
	input wire sel_i,
	input wire [1:0] htrans_i,
	input wire hready_i,
	output reg hreadyout_o,
	output reg hresp_o
);

	localparam [3:0] ST_OKAY = 4'h1;
	localparam [3:0] ST_WAIT = 4'h2;
	localparam [3:0] ST_ERR1 = 4'h4;
	localparam [3:0] ST_ERR2 = 4'h8;

	reg [3:0] state_q;
	reg [3:0] state_d;
	reg [4:0] wait_q;
	reg [4:0] wait_d;
	wire start_err;

	// only sample select and type while the bus is advancing
	assign start_err = sel_i & hready_i & htrans_i[1];

	always @* begin
		state_d = state_q;
		wait_d = wait_q;
		case (state_q)
			ST_OKAY: begin
				// idle or busy stays here: zero-wait okay
				if (start_err) begin
					if (ERR_WAITS == 0) begin
						state_d = ST_ERR1;
					end else begin
						state_d = ST_WAIT;
						wait_d = 5'h01;
					end
				end
			end
			ST_WAIT: begin
				if (wait_q >= ERR_WAITS[4:0]) begin
					state_d = ST_ERR1;
				end else begin
					wait_d = wait_q + 5'h01;
				end
			end
			ST_ERR1: begin
				state_d = ST_ERR2;
			end
			ST_ERR2: begin
				// a new nonseq may be taken in the second error cycle
				if (start_err) begin
					if (ERR_WAITS == 0) begin
						state_d = ST_ERR1;
					end else begin
						state_d = ST_WAIT;
						wait_d = 5'h01;
					end
				end else begin
					state_d = ST_OKAY;
				end
			end
			default: begin
				state_d = ST_OKAY;
			end
		endcase
	end

	always @(posedge clock_i) begin
		if (!rst_b_i) begin
			state_q <= ST_OKAY;
			wait_q <= 5'h00;
			hreadyout_o <= 1'b1;
			hresp_o <= `RESP_OKAY;
		end else begin
			state_q <= state_d;
			wait_q <= wait_d;
			hreadyout_o <= (state_d == ST_OKAY) | (state_d == ST_ERR2);
			// okay during wait cycles, error for both error cycles
			hresp_o <= (state_d == ST_ERR1) | (state_d == ST_ERR2);
		end
	end

endmodule

// ===== src/decode_response_fabric.v
// Operation
// - select per slave, combinational from high address
// - capture select only while ready is high
// - every region spans at least 1KB
// - default slave answers unmapped addresses
// - default slave errors nonseq and seq
// - default slave okays idle/busy, zero waits
// - broadcast address; mux response back centrally
// - only slave ends a started transfer
// - response bit: zero okay, one error
// - response and ready decoded together
// - wait cycles always carry okay response
// - bounded wait count, normally sixteen
// - error is two cycles: low then high
// - error may follow okay wait cycles
`timescale 1ns/1ps
`include "fabric_defines.vh"

module decode_response_fabric #(
	parameter NSLV = `SLAVE_COUNT,
	parameter AW = `ADDR_WIDTH,
	parameter DW = `DATA_WIDTH,
	parameter [NSLV*(AW-`REGION_LSB)-1:0] SLV_BASE =
		{`SLAVE2_BASE, `SLAVE1_BASE, `SLAVE0_BASE},
	parameter [NSLV*(AW-`REGION_LSB)-1:0] SLV_MASK =
		{`SLAVE2_MASK, `SLAVE1_MASK, `SLAVE0_MASK},
	parameter MAX_WAITS = `MAX_WAITS,
	parameter ERR_WAITS = `DEFAULT_ERR_WAITS
) (
	input wire clock_i,
	input wire rst_b_i,
	input wire [AW-1:0] haddr_i,
	input wire [1:0] htrans_i,
	input wire [NSLV-1:0] s_hreadyout_i,
	input wire [NSLV-1:0] s_hresp_i,
	input wire [NSLV*DW-1:0] s_hrdata_i,
	output reg [NSLV-1:0] hsel_o,
	output reg hready_o,
	output reg hresp_o,
	output reg [DW-1:0] hrdata_o,
	output reg err_first_o,
	output reg err_done_o,
	output reg wait_overrun_o,
	output reg resp_fault_o
);

	localparam RW = AW - `REGION_LSB;

	// ==========================================================
	// helpers
	// ==========================================================
	function region_hit;
		input [RW-1:0] page;
		input [RW-1:0] base;
		input [RW-1:0] mask;
		begin
			region_hit = ((page & mask) == (base & mask));
		end
	endfunction

	// ==========================================================
	// address decoder
	// ==========================================================
	reg hsel_default;
	reg [NSLV-1:0] hits;
	integer i;
	integer j;

	// low ten bits never reach the compare, so no boundary inside 1KB
	always @* begin
		hits = {NSLV{1'b0}};
		hsel_o = {NSLV{1'b0}};
		for (i = 0; i < NSLV; i = i + 1) begin
			hits[i] = region_hit(haddr_i[AW-1:`REGION_LSB],
				SLV_BASE[i*RW +: RW], SLV_MASK[i*RW +: RW]);
		end
		// overlapping regions resolve to the lowest index
		for (i = NSLV - 1; i >= 0; i = i - 1) begin
			if (hits[i]) begin
				hsel_o = {NSLV{1'b0}};
				hsel_o[i] = 1'b1;
			end
		end
		hsel_default = ~|hits;
	end

	// ==========================================================
	// default slave
	// ==========================================================
	wire def_hreadyout;
	wire def_hresp;

	default_responder #(
		.ERR_WAITS(ERR_WAITS)
	) u_default (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.sel_i(hsel_default),
		.htrans_i(htrans_i),
		.hready_i(hready_o),
		.hreadyout_o(def_hreadyout),
		.hresp_o(def_hresp)
	);

	// ==========================================================
	// data phase owner
	// ==========================================================
	// bit NSLV is the default slave; all zero right after reset
	reg [NSLV:0] dsel_q;

	always @(posedge clock_i) begin
		if (!rst_b_i) begin
			dsel_q <= {(NSLV+1){1'b0}};
		end else if (hready_o) begin
			// a select seen in a waited cycle may be stale, so ignore it
			dsel_q <= {hsel_default, hsel_o};
		end
	end

	// ==========================================================
	// response multiplexor
	// ==========================================================
	// stays combinational: the answer must reach master and slaves
	// in the same cycle the owning slave gives it
	always @* begin
		hready_o = 1'b1;
		hresp_o = `RESP_OKAY;
		hrdata_o = {DW{1'b0}};
		for (j = 0; j < NSLV; j = j + 1) begin
			if (dsel_q[j]) begin
				hready_o = s_hreadyout_i[j];
				hresp_o = s_hresp_i[j];
				hrdata_o = s_hrdata_i[j*DW +: DW];
			end
		end
		if (dsel_q[NSLV]) begin
			hready_o = def_hreadyout;
			hresp_o = def_hresp;
		end
	end

	// ==========================================================
	// response watch
	// ==========================================================
	reg [7:0] wait_cnt_q;
	reg err1_q;
	wire resp_pending;
	wire resp_err1;
	wire resp_err2;

	assign resp_pending = ~hready_o & (hresp_o == `RESP_OKAY);
	assign resp_err1 = ~hready_o & (hresp_o == `RESP_ERROR);
	assign resp_err2 = hready_o & (hresp_o == `RESP_ERROR);

	always @(posedge clock_i) begin
		if (!rst_b_i) begin
			wait_cnt_q <= 8'h00;
			wait_overrun_o <= 1'b0;
			err1_q <= 1'b0;
			err_first_o <= 1'b0;
			err_done_o <= 1'b0;
			resp_fault_o <= 1'b0;
		end else begin
			// wait budget covers okay wait cycles only
			if (hready_o) begin
				wait_cnt_q <= 8'h00;
				wait_overrun_o <= 1'b0;
			end else if (resp_pending) begin
				if (wait_cnt_q != 8'hFF) begin
					wait_cnt_q <= wait_cnt_q + 8'h01;
				end
				if (wait_cnt_q >= MAX_WAITS[7:0]) begin
					wait_overrun_o <= 1'b1;
				end
			end
			err1_q <= resp_err1;
			// lets the master drop the pipelined access in time
			err_first_o <= resp_err1;
			err_done_o <= resp_err2;
			// error must be exactly first cycle then second cycle
			resp_fault_o <= (err1_q & ~resp_err2) | (resp_err2 & ~err1_q);
		end
	end

endmodule

// ===== verif/fabric_chk.sv
`timescale 1ns/1ps
module fabric_chk (
	input wire clock_i,
	input wire rst_b_i,
	input wire [31:0] haddr_i,
	input wire [1:0] htrans_i,
	input wire [2:0] s_hreadyout_i,
	input wire [2:0] s_hresp_i,
	input wire [2:0] hsel_o,
	input wire hready_o,
	input wire hresp_o,
	input wire err_first_o,
	input wire err_done_o,
	input wire wait_overrun_o
);
	// ====
	// decode, default slave, response mux
	wire [15:0] pg = haddr_i[31:16];
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	property p_map; hsel_o == {pg == 16'h4000, pg == 16'h2000, pg == 16'h0000}; endproperty
	a_map: assert property (p_map) else $error("bad select");
	property p_derr; hready_o && hsel_o == 3'h0 && htrans_i[1] |=> !hready_o && hresp_o; endproperty
	a_derr: assert property (p_derr) else $error("no default error");
	property p_dok; hready_o && hsel_o == 3'h0 && !htrans_i[1] |=> hready_o && !hresp_o; endproperty
	a_dok: assert property (p_dok) else $error("no default okay");
	property p_err2; !hready_o && hresp_o |=> hready_o && hresp_o; endproperty
	a_err2: assert property (p_err2) else $error("error not two cycles");
	property p_mux; hready_o && hsel_o[1] |=> hready_o == s_hreadyout_i[1] && hresp_o == s_hresp_i[1]; endproperty
	a_mux: assert property (p_mux) else $error("mux not from owner");
	// a select change during a wait must not steal the data phase
	property p_hold; hready_o && hsel_o[2] ##1 !hready_o |=> hready_o == s_hreadyout_i[2]; endproperty
	a_hold: assert property (p_hold) else $error("owner lost in wait");
	property p_flag; !hready_o && hresp_o |=> err_first_o; endproperty
	a_flag: assert property (p_flag) else $error("first error not flagged");
	property p_done; hready_o && hresp_o |=> err_done_o; endproperty
	a_done: assert property (p_done) else $error("second error not flagged");
	property p_ovr; hready_o |=> !wait_overrun_o; endproperty
	a_ovr: assert property (p_ovr) else $error("overrun not cleared");
endmodule
bind decode_response_fabric fabric_chk chk (.clock_i, .rst_b_i, .haddr_i, .htrans_i,
	.s_hreadyout_i, .s_hresp_i, .hsel_o, .hready_o, .hresp_o, .err_first_o, .err_done_o,
	.wait_overrun_o);

// ===== verif/slave_models.sv
`timescale 1ns/1ps
module slave_models (
	input wire clock_i,
	input wire rst_b_i,
	input wire [2:0] hsel_i,
	input wire hready_i,
	input wire [1:0] htrans_i,
	input wire [4:0] waits_i,
	input wire err_i,
	output wire [2:0] hreadyout_o,
	output wire [2:0] hresp_o,
	output wire [95:0] hrdata_o
);
	// ====
	// three slaves, waits and error set by the bench
	genvar k;
	generate
		for (k = 0; k < 3; k = k + 1) begin : g_slv
			reg busy_q;
			reg err_q;
			reg late_q;
			reg [4:0] cnt_q;
			wire last = busy_q && cnt_q == 5'h0;
			always @(posedge clock_i) begin
				if (!rst_b_i) begin
					busy_q <= 1'b0;
					late_q <= 1'b0;
				end else if (hready_i && hsel_i[k] && htrans_i[1]) begin
					busy_q <= 1'b1;
					cnt_q <= waits_i;
					err_q <= err_i;
					late_q <= 1'b0;
				end else if (busy_q && cnt_q != 5'h0) begin
					cnt_q <= cnt_q - 5'h1;
				end else if (last && err_q && !late_q) begin
					late_q <= 1'b1;
				end else begin
					busy_q <= 1'b0;
				end
			end
			assign hreadyout_o[k] = !busy_q || (last && (!err_q || late_q));
			assign hresp_o[k] = last && err_q;
			// data is only valid on okay completion; inverted otherwise
			assign hrdata_o[k*32 +: 32] = (last && !err_q) ? 32'hC0DE0000 + k : ~(32'hC0DE0000 + k);
		end
	endgenerate
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`include "fabric_defines.vh"
module tb_top;
	reg clock_i = 1'b0;
	reg rst_b_i = 1'b0;
	reg [31:0] haddr = 32'h0;
	reg [1:0] htrans = 2'h0;
	reg [4:0] waits = 5'h0;
	reg err = 1'b0;
	reg [31:0] a, rnd;
	wire [2:0] rdy, resp, hsel;
	wire [95:0] data;
	wire [31:0] hrdata;
	wire hready, hresp, ovr, ef, ed, rf;
	integer failures = 0;
	integer num_checks = 0;
	integer i;
	decode_response_fabric dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .haddr_i(haddr),
		.htrans_i(htrans), .s_hreadyout_i(rdy), .s_hresp_i(resp), .s_hrdata_i(data),
		.hsel_o(hsel), .hready_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .err_first_o(ef),
		.err_done_o(ed), .wait_overrun_o(ovr), .resp_fault_o(rf));
	slave_models far (.clock_i(clock_i), .rst_b_i(rst_b_i), .hsel_i(hsel), .hready_i(hready),
		.htrans_i(htrans), .waits_i(waits), .err_i(err), .hreadyout_o(rdy), .hresp_o(resp),
		.hrdata_o(data));
	initial forever #12.5 clock_i = ~clock_i;
	// ====
	// checking and transfers
	task chk(input [31:0] got, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("[FAIL] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	function [2:0] exp_sel(input [31:0] x);
		exp_sel = {x[31:16] == 16'h4000, x[31:16] == 16'h2000, x[31:16] == 16'h0000};
	endfunction
	task xfer(input [31:0] x, input [1:0] t);
		integer n, w;
		reg act, er;
		begin
			haddr = x;
			htrans = t;
			act = t[1] && exp_sel(x) != 3'h0;
			er = t[1] && (!act || err);
			w = act ? waits : 0;
			#1 chk(hsel, exp_sel(x));
			@(negedge clock_i);
			haddr = ~x;
			htrans = `TRANS_IDLE;
			for (n = 0; n < w; n = n + 1) begin
				chk({hready, hresp}, 2'h0);
				chk(ovr, n > 16);
				@(negedge clock_i);
			end
			if (er) begin
				chk({hready, hresp}, 2'h1);
				@(negedge clock_i);
				chk(ef, 1'b1);
			end
			chk({hready, hresp}, {1'b1, er});
			if (act && !er) chk(hrdata, 32'hC0DE0000 + exp_sel(x) / 2);
			if (exp_sel(x) == 3'h0) chk(hrdata, 32'h0);
			@(negedge clock_i);
			chk({ed, rf}, {er, 1'b0});
		end
	endtask
	// back to back zero-wait beats, all inside one 1KB block
	task burst(input [31:0] x, input integer beats);
		integer b;
		begin
			waits = 5'h00;
			err = 1'b0;
			haddr = x;
			htrans = `TRANS_NONSEQ;
			for (b = 1; b <= beats; b = b + 1) begin
				@(negedge clock_i);
				chk({hready, hresp}, 2'h2);
				chk(hrdata, 32'hC0DE0000 + exp_sel(x) / 2);
				haddr = x + 4 * b;
				htrans = (b < beats) ? `TRANS_SEQ : `TRANS_IDLE;
			end
			@(negedge clock_i);
		end
	endtask
	task end_of_test;
		begin
			$display("checks %0d failures %0d", num_checks, failures);
			if (failures == 0 && num_checks > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	initial begin
		#100000;
		failures = failures + 1;
		end_of_test;
	end
	initial begin
		rnd = $urandom(32'h4704);
		repeat (2) @(posedge clock_i);
		@(negedge clock_i);
		rst_b_i = 1'b1;
		for (i = 0; i < 200; i = i + 1) begin
			rnd = $urandom;
			a = $urandom;
			waits = {3'h0, rnd[1:0]};
			err = rnd[2];
			a[31:16] = (rnd[4:3] == 2'h3) ? 16'hF000 | a[31:16] : {1'b0, rnd[4:3], 13'h0000};
			xfer(a, rnd[6:5]);
		end
		$display("random transfers done");
		waits = 5'h12;
		err = 1'b0;
		xfer(32'h20000000, `TRANS_NONSEQ);
		waits = 5'h2;
		err = 1'b1;
		xfer(32'h4000FFFC, `TRANS_SEQ);
		xfer(32'h00010000, `TRANS_SEQ);
		xfer(32'h0000FFFC, `TRANS_NONSEQ);
		xfer(32'hFFFFFFFF, `TRANS_BUSY);
		burst(32'h400003F0, 4);
		burst(32'h00000000, 3);
		// master keeps going after an error: default slave must restart in its second cycle
		haddr = 32'hF0000000;
		htrans = `TRANS_NONSEQ;
		@(negedge clock_i);
		haddr = 32'hF0000400;
		for (i = 0; i < 4; i = i + 1) begin
			chk({hready, hresp}, {i[0], 1'b1});
			if (i == 2) htrans = `TRANS_IDLE;
			@(negedge clock_i);
		end
		chk({hready, hresp}, 2'h2);
		chk({ed, rf}, 2'h2);
		$display("corner transfers done");
		end_of_test;
	end
endmodule
